/* verilog/cbl_core.sv */
`timescale 1ns/1ps
module cbl_core
   import cbl_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // program memory fetch
   output logic [15:0] code_addr,
   input wire logic [7:0] code_data,
   // data space (ram, sfr, working registers)
   output cbl_pkg::cbl_mem_type mem_req,
   input wire logic [7:0] mem_rdata,
   // bit space; port bits return their latch
   output cbl_pkg::cbl_bit_type bit_req,
   input wire logic bit_rdata,
   // working-register read for Rn and @Ri forms
   output logic [2:0] reg_sel,
   input wire logic [7:0] reg_rdata,
   // architectural state
   output logic [15:0] pc,
   output logic [7:0] acc,
   output logic [7:0] breg,
   output logic [15:0] pointer16_reg,
   output logic carry,
   output logic signed_wrap_flag
);
   import cbl_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // state
   cbl_state_type st_q, st_d;
   logic [15:0] pc_q, pc_d; // program counter
   logic [7:0] op_q, op_d; // latched opcode
   logic [7:0] b1_q, b1_d; // first operand byte
   logic [7:0] acc_q, acc_d;
   logic [7:0] b_q, b_d;
   logic [15:0] dp_q, dp_d;
   logic c_q, c_d;
   logic ov_q, ov_d;

   assign pc = pc_q;
   assign acc = acc_q;
   assign breg = b_q;
   assign pointer16_reg = dp_q;
   assign carry = c_q;
   assign signed_wrap_flag = ov_q;
   assign code_addr = pc_q;

   ////////////////////////////////////////////////////////////////////
   // decode
   wire is_page = (op_q[4:0] == OP_PAGE_JUMP_LOW5);
   wire is_and = (op_q[7:4] == GRP_AND) && (op_q >= OP_AND_DIR_A);
   wire is_cmp = (op_q[7:4] == GRP_CMP) && (op_q >= OP_CMP_A_IMM);
   wire is_dec = (op_q[7:4] == GRP_DEC) && (op_q[3:0] >= 4'h4);
   wire is_inc = (op_q[7:4] == GRP_INC) && (op_q[3:0] >= 4'h4);
   wire is_cnt_reg = (op_q[7:3] == GRP_CNT_REG);
   wire is_cnt = is_cnt_reg || (op_q == OP_CNT_DIR);
   wire is_bitop = (op_q == OP_AND_C_BIT) || (op_q == OP_AND_C_NBIT) ||
      (op_q == OP_ZERO_BIT) || (op_q == OP_INV_BIT) ||
      (op_q == OP_BR_BIT) || (op_q == OP_BR_CLR);
   // operand source: A, direct byte, @Ri or Rn (low opcode bits)
   wire [3:0] lo = op_q[3:0];
   wire src_dir = (lo == 4'h5);
   wire src_ind = (lo == 4'h6) || (lo == 4'h7);
   wire src_reg = lo[3];
   // direct byte from which to read: first operand byte, or the @Ri register contents for the indirect forms
   wire [7:0] dir_addr = src_ind ? reg_rdata : b1_q;
   assign reg_sel = src_ind ? {2'b00, lo[0]} : lo[2:0];
   wire [7:0] opnd = src_reg ? reg_rdata : mem_rdata;
   // instruction length decides how many operand bytes follow
   // the three-byte and-immediate carries its direct address in byte 1 too
   wire need_b1 = is_page || is_bitop || src_dir || (op_q == OP_AND_DIR_A) ||
      (op_q == OP_AND_A_IMM) || (op_q == OP_AND_DIR_IMM) || is_cmp || is_cnt ||
      (op_q == OP_BR_C);
   wire need_b2 = is_cmp || (op_q == OP_BR_BIT) || (op_q == OP_BR_CLR) ||
      (op_q == OP_CNT_DIR) || (op_q == OP_AND_DIR_IMM);
   // relative target from next instruction address
   wire [7:0] rel = need_b2 ? code_data : b1_q;
   wire [15:0] rel_tgt = pc_q + {{8{rel[7]}}, rel};
   // compare operands
   wire [7:0] cmp_l = (lo == 4'h4 || lo == 4'h5) ? acc_q : opnd;
   wire [7:0] cmp_r = (lo == 4'h5) ? mem_rdata : b1_q;
   // bcd adjust
   wire bcd_lo = c_q || (acc_q[3:0] > BCD_NIB_MAX);
   wire [8:0] bcd1 = {1'b0, acc_q} + (bcd_lo ? {1'b0, BCD_LO_FIX} : 9'h000);
   wire bcd_hi = c_q || bcd_lo;
   wire [8:0] bcd2 = bcd1 + (bcd_hi ? {1'b0, BCD_HI_FIX} : 9'h000);
   // count-down target value
   wire [7:0] cnt_old = is_cnt_reg ? reg_rdata : mem_rdata;
   wire [7:0] cnt_new = cnt_old - 8'h01; // wraps 0 -> ff

   ////////////////////////////////////////////////////////////////////
   // data and bit request steering
   always_comb begin
      mem_req = '0;
      bit_req = '0;
      mem_req.addr = (op_q == OP_CNT_DIR) ? b1_q : dir_addr;
      bit_req.bit_location = b1_q;
      if (st_q == ST_EX) begin
         if (is_and && (op_q == OP_AND_DIR_A)) begin
            mem_req.wr = 1'b1; // result to first operand
            mem_req.wdata = mem_rdata & acc_q;
         end else if (op_q == OP_AND_DIR_IMM) begin
            mem_req.wr = 1'b1;
            mem_req.wdata = mem_rdata & code_data;
         end else if ((is_dec || is_inc) && lo != 4'h4) begin
            mem_req.wr = 1'b1; // 8-bit wrap, carry untouched
            mem_req.wdata = is_dec ? opnd - 8'h01 : opnd + 8'h01;
            if (src_reg) mem_req.addr = {5'h00, lo[2:0]};
         end else if (is_cnt) begin
            mem_req.wr = 1'b1;
            mem_req.wdata = cnt_new;
            if (is_cnt_reg) mem_req.addr = {5'h00, lo[2:0]};
         end else if (op_q == OP_ZERO_BIT) begin
            bit_req.wr = 1'b1; // one bit only
            bit_req.wval = 1'b0;
         end else if (op_q == OP_INV_BIT) begin
            bit_req.wr = 1'b1; // inverts returned latch
            bit_req.wval = ~bit_rdata;
         end else if (op_q == OP_BR_CLR && bit_rdata) begin
            bit_req.wr = 1'b1; // cleared only when taken
            bit_req.wval = 1'b0;
         end
      end
      // direct space split
      mem_req.is_sfr = (mem_req.addr >= SFR_BASE);
   end

   ////////////////////////////////////////////////////////////////////
   // execute
   always_comb begin
      st_d = st_q;
      pc_d = pc_q;
      op_d = op_q;
      b1_d = b1_q;
      acc_d = acc_q;
      b_d = b_q;
      dp_d = dp_q;
      c_d = c_q;
      ov_d = ov_q;
      unique case (st_q)
         ST_OP: begin
            op_d = code_data;
            pc_d = pc_q + 16'h0001;
            st_d = ST_B1;
         end
         ST_B1: begin
            if (need_b1) begin
               b1_d = code_data;
               pc_d = pc_q + 16'h0001;
            end
            st_d = ST_EX;
         end
         ST_EX: begin
            st_d = ST_OP;
            if (need_b2) pc_d = pc_q + 16'h0001;
            if (is_page) begin
               // page select keeps PC[15:11] of next address
               pc_d = {pc_q[15:11], op_q[7:5], b1_q};
            end else if (is_and && op_q != OP_AND_DIR_A && op_q != OP_AND_DIR_IMM) begin
               acc_d = acc_q & ((op_q == OP_AND_A_IMM) ? b1_q : opnd);
            end else if (is_cmp) begin
               c_d = (cmp_l < cmp_r);
               if (cmp_l != cmp_r) pc_d = rel_tgt + 16'h0001;
            end else if (is_cnt) begin
               if (cnt_new != 8'h00) pc_d = rel_tgt + (need_b2 ? 16'h0001 : 16'h0000);
            end else if (op_q == OP_BR_BIT || op_q == OP_BR_CLR) begin
               if (bit_rdata) pc_d = rel_tgt + 16'h0001;
            end else if (op_q == OP_BR_C) begin
               if (c_q) pc_d = rel_tgt;
            end else if (op_q == OP_AND_C_BIT) begin
               c_d = c_q & bit_rdata;
            end else if (op_q == OP_AND_C_NBIT) begin
               c_d = c_q & ~bit_rdata; // source bit not written
            end else if (op_q == OP_ZERO_C) begin
               c_d = 1'b0;
            end else if (op_q == OP_ZERO_A) begin
               acc_d = BYTE_RST;
            end else if (op_q == OP_INV_A) begin
               acc_d = ~acc_q;
            end else if (op_q == OP_INV_C) begin
               c_d = ~c_q;
            end else if (op_q == OP_BCD) begin
               acc_d = bcd2[7:0];
               c_d = (bcd2 > {1'b0, BCD_MAX});
            end else if (op_q == OP_DEC_A) begin
               acc_d = acc_q - 8'h01;
            end else if (op_q == OP_INC_A) begin
               acc_d = acc_q + 8'h01;
            end else if (op_q == OP_DIVIDE) begin
               c_d = 1'b0;
               ov_d = (b_q == 8'h00);
               if (b_q != 8'h00) begin
                  acc_d = acc_q / b_q;
                  b_d = acc_q % b_q;
               end
            end else if (op_q == OP_INC_PTR) begin
               dp_d = dp_q + 16'h0001;
            end else if (op_q == OP_IDX_JUMP) begin
               pc_d = dp_q + {8'h00, acc_q};
            end
         end
         default: st_d = ST_OP;
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // registers
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_q <= ST_OP;
         pc_q <= PC_RST;
         op_q <= BYTE_RST;
         b1_q <= BYTE_RST;
         acc_q <= BYTE_RST;
         b_q <= BYTE_RST;
         dp_q <= PC_RST;
         c_q <= 1'b0;
         ov_q <= 1'b0;
      end else begin
         st_q <= st_d;
         pc_q <= pc_d;
         op_q <= op_d;
         b1_q <= b1_d;
         acc_q <= acc_d;
         b_q <= b_d;
         dp_q <= dp_d;
         c_q <= c_d;
         ov_q <= ov_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // checks
   property p_page;
      @(posedge clk) disable iff (!rstn)
      (st_q == ST_EX && is_page) |=> (pc_q[10:0] == {$past(op_q[7:5]), $past(b1_q)});
   endproperty
   a_page: assert property (p_page) else $error("page jump target wrong");
   property p_page_hi;
      @(posedge clk) disable iff (!rstn)
      (st_q == ST_EX && is_page) |=> (pc_q[15:11] == $past(pc_q[15:11]));
   endproperty
   a_page_hi: assert property (p_page_hi) else $error("page jump left region");
   property p_div_ov;
      @(posedge clk) disable iff (!rstn)
      (st_q == ST_EX && op_q == OP_DIVIDE) |=> (ov_q == ($past(b_q) == 8'h00)) && !c_q;
   endproperty
   a_div_ov: assert property (p_div_ov) else $error("divide flags wrong");
   property p_ptr;
      @(posedge clk) disable iff (!rstn)
      (st_q == ST_EX && op_q == OP_INC_PTR) |=> (dp_q == $past(dp_q) + 16'h0001);
   endproperty
   a_ptr: assert property (p_ptr) else $error("pointer increment wrong");
   property p_idx;
      @(posedge clk) disable iff (!rstn)
      (st_q == ST_EX && op_q == OP_IDX_JUMP) |=> (pc_q == $past(dp_q) + {8'h00, $past(acc_q)});
   endproperty
   a_idx: assert property (p_idx) else $error("indexed jump wrong");
   property p_jc;
      @(posedge clk) disable iff (!rstn)
      (st_q == ST_EX && op_q == OP_BR_C && !c_q) |=> (pc_q == $past(pc_q));
   endproperty
   a_jc: assert property (p_jc) else $error("carry branch taken wrongly");
   property p_inva;
      @(posedge clk) disable iff (!rstn)
      (st_q == ST_EX && op_q == OP_INV_A) |=> (acc_q == ~$past(acc_q)) && (c_q == $past(c_q));
   endproperty
   a_inva: assert property (p_inva) else $error("accumulator invert wrong");
   property p_bcd_c;
      @(posedge clk) disable iff (!rstn)
      (st_q == ST_EX && op_q == OP_BCD) |=> (c_q == $past(bcd2 > 9'h099));
   endproperty
   a_bcd_c: assert property (p_bcd_c) else $error("bcd carry wrong");
   property p_inc_c;
      @(posedge clk) disable iff (!rstn)
      (st_q == ST_EX && (is_inc || is_dec)) |=> (c_q == $past(c_q));
   endproperty
   a_inc_c: assert property (p_inc_c) else $error("carry changed by step");
endmodule

/* pkg/cbl_pkg.sv */
package cbl_pkg;
   // opcodes handled by this slice of the core
   localparam logic [7:0] OP_PAGE_JUMP_LO = 8'h01;
   localparam logic [4:0] OP_PAGE_JUMP_LOW5 = 5'h01;
   localparam logic [7:0] OP_AND_DIR_A = 8'h52;
   localparam logic [7:0] OP_AND_DIR_IMM = 8'h53;
   localparam logic [7:0] OP_AND_A_IMM = 8'h54;
   localparam logic [7:0] OP_AND_A_DIR = 8'h55;
   localparam logic [7:0] OP_AND_C_BIT = 8'h82;
   localparam logic [7:0] OP_AND_C_NBIT = 8'hb0;
   localparam logic [7:0] OP_CMP_A_IMM = 8'hb4;
   localparam logic [7:0] OP_CMP_A_DIR = 8'hb5;
   localparam logic [7:0] OP_ZERO_BIT = 8'hc2;
   localparam logic [7:0] OP_ZERO_C = 8'hc3;
   localparam logic [7:0] OP_ZERO_A = 8'he4;
   localparam logic [7:0] OP_INV_A = 8'hf4;
   localparam logic [7:0] OP_INV_C = 8'hb3;
   localparam logic [7:0] OP_INV_BIT = 8'hb2;
   localparam logic [7:0] OP_BCD = 8'hd4;
   localparam logic [7:0] OP_DEC_A = 8'h14;
   localparam logic [7:0] OP_DEC_DIR = 8'h15;
   localparam logic [7:0] OP_DIVIDE = 8'h84;
   localparam logic [7:0] OP_CNT_DIR = 8'hd5;
   localparam logic [7:0] OP_INC_A = 8'h04;
   localparam logic [7:0] OP_INC_DIR = 8'h05;
   localparam logic [7:0] OP_INC_PTR = 8'ha3;
   localparam logic [7:0] OP_BR_BIT = 8'h20;
   localparam logic [7:0] OP_BR_CLR = 8'h10;
   localparam logic [7:0] OP_BR_C = 8'h40;
   localparam logic [7:0] OP_IDX_JUMP = 8'h73;
   // opcode group prefixes (high nibble; high five bits for GRP_CNT_REG) and range markers
   localparam logic [3:0] GRP_AND = 4'h5;
   localparam logic [3:0] GRP_CMP = 4'hb;
   localparam logic [3:0] GRP_DEC = 4'h1;
   localparam logic [3:0] GRP_INC = 4'h0;
   localparam logic [4:0] GRP_CNT_REG = 5'h1b;
   // bcd constants
   localparam logic [7:0] BCD_LO_FIX = 8'h06;
   localparam logic [7:0] BCD_HI_FIX = 8'h60;
   localparam logic [7:0] BCD_MAX = 8'h99;
   localparam logic [3:0] BCD_NIB_MAX = 4'h9;
   // direct space split: ram below, sfr from here
   localparam logic [7:0] SFR_BASE = 8'h80;
   // reset values
   localparam logic [15:0] PC_RST = 16'h0000;
   localparam logic [7:0] BYTE_RST = 8'h00;

   // one-hot sequencer
   typedef enum logic [3:0] {
      ST_OP = 4'h1,
      ST_B1 = 4'h2,
      ST_B2 = 4'h4,
      ST_EX = 4'h8
   } cbl_state_type;

   // data-space access request
   typedef struct packed {
      logic wr;
      logic is_sfr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } cbl_mem_type;

   // bit-space access request
   typedef struct packed {
      logic wr;
      logic [7:0] bit_location;
      logic wval;
   } cbl_bit_type;
endpackage

/* tb/cbl_far_model.sv */
`timescale 1ns/1ps
// far side: code rom, data space and bit space
module cbl_far_model
   import cbl_pkg::*;
(
   // clock
   input wire logic clk,
   // fetch path
   input wire logic [15:0] code_addr,
   output logic [7:0] code_data,
   // data and working registers
   input wire cbl_pkg::cbl_mem_type mem_req,
   output logic [7:0] mem_rdata,
   input wire logic [2:0] reg_sel,
   output logic [7:0] reg_rdata,
   // bit space
   input wire cbl_pkg::cbl_bit_type bit_req,
   output logic bit_rdata
);
   logic [7:0] rom [0:65535]; // code bytes, loaded by the bench
   logic [7:0] ram [0:255]; // ram below 80, sfr from 80 up
   logic bits [0:255]; // port bits keep the latch, no pin is modelled
   ////////////////////////////////////////////////////////////////////
   // same-cycle reads, as the core expects
   assign code_data = rom[code_addr];
   assign mem_rdata = ram[mem_req.addr];
   assign reg_rdata = ram[{5'h00, reg_sel}]; // working registers live at 0..7
   assign bit_rdata = bits[bit_req.bit_location];
   // writes land on the edge that ends execute
   always @(posedge clk) begin
      if (mem_req.wr === 1'b1) begin
         ram[mem_req.addr] <= mem_req.wdata;
      end
      if (bit_req.wr === 1'b1) begin
         bits[bit_req.bit_location] <= bit_req.wval;
      end
   end
endmodule

/* tb/cbl_core_bench.sv */
`timescale 1ns/1ps
module cbl_core_bench;
   import cbl_pkg::*;
   // expected state after one instruction
   typedef struct packed {
      logic [15:0] pc;
      logic [7:0] a;
      logic [15:0] dp;
      logic c;
      logic ov;
      logic [7:0] ma;
      logic [7:0] mv;
      logic [7:0] ba;
      logic bv;
   } cbl_exp_type;
   localparam logic [7:0] NB = 8'h00; // filler byte
   localparam logic [7:0] D = 8'h40; // direct ram byte under test
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [15:0] code_addr, pc, pointer16_reg;
   logic [7:0] code_data, mem_rdata, reg_rdata, acc, breg, imm, off;
   logic bit_rdata, carry, signed_wrap_flag, tk;
   logic [2:0] reg_sel;
   cbl_mem_type mem_req;
   cbl_bit_type bit_req;
   int err_total = 0;
   int cmp_count = 0;
   int phase = 0; // cycle within the fixed 3-cycle instruction
   logic [31:0] rnd = 32'h96d3;
   cbl_exp_type e; // running expectation
   cbl_exp_type expq [$];
   logic [7:0] sh [0:255]; // shadow of the data space
   logic shb [0:255]; // shadow of the bit space
   ////////////////////////////////////////////////////////////////////
   cbl_core cbl_core_inst (.clk(clk), .rstn(rstn), .code_addr(code_addr),
      .code_data(code_data), .mem_req(mem_req), .mem_rdata(mem_rdata), .bit_req(bit_req),
      .bit_rdata(bit_rdata), .reg_sel(reg_sel), .reg_rdata(reg_rdata), .pc(pc), .acc(acc),
      .breg(breg), .pointer16_reg(pointer16_reg), .carry(carry),
      .signed_wrap_flag(signed_wrap_flag));
   cbl_far_model cbl_far_model_inst (.clk(clk), .code_addr(code_addr),
      .code_data(code_data), .mem_req(mem_req), .mem_rdata(mem_rdata), .reg_sel(reg_sel),
      .reg_rdata(reg_rdata), .bit_req(bit_req), .bit_rdata(bit_rdata));
   always #4 clk = ~clk;
   ////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // fall-through and relative target, both from the following byte
   function automatic logic [15:0] nx(input int n);
      return e.pc + 16'(n);
   endfunction
   function automatic logic [15:0] br(input int n, input logic [7:0] o);
      return e.pc + 16'(n) + {{8{o[7]}}, o};
   endfunction
   function automatic logic [15:0] pj(input logic [7:0] op, input logic [7:0] lo);
      logic [15:0] t;
      t = e.pc + 16'h0002;
      return {t[15:11], op[7:5], lo};
   endfunction
   task automatic cmp(input string nm, input logic [15:0] x, input logic [15:0] y);
      cmp_count++;
      if (x !== y) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, x, y);
      end
   endtask
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // place one instruction at the expected pc and note the outcome
   task automatic issue(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2,
         input logic [15:0] npc, input logic [7:0] a);
      cbl_far_model_inst.rom[e.pc] <= b0;
      cbl_far_model_inst.rom[e.pc + 16'h0001] <= b1;
      cbl_far_model_inst.rom[e.pc + 16'h0002] <= b2;
      e.pc = npc;
      e.a = a;
      e.mv = sh[e.ma];
      e.bv = shb[e.ba];
      expq.push_back(e);
      repeat (3) @(posedge clk);
   endtask
   // only accumulator ops can load it, so go through zero, invert, and
   task automatic load_a(input logic [7:0] v);
      issue(OP_ZERO_A, NB, NB, nx(1), 8'h00);
      issue(OP_INV_A, NB, NB, nx(1), 8'hff);
      issue(OP_AND_A_IMM, v, NB, nx(2), v);
   endtask
   task automatic set_c(input logic v);
      if (e.c !== v) begin
         e.c = v;
         issue(OP_INV_C, NB, NB, nx(1), e.a);
      end
   endtask
   ////////////////////////////////////////////////////////////////////
   // instruction boundary: the edge that ends execute
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         phase <= 0;
      end else begin
         phase <= (phase == 2) ? 0 : phase + 1;
      end
   end
   // watcher: compare the oldest note once the instruction retires
   always @(posedge clk) begin
      cbl_exp_type x;
      if (rstn === 1'b1 && phase == 2 && expq.size() > 0) begin
         @(negedge clk);
         x = expq.pop_front();
         cmp("pc", x.pc, pc);
         cmp("acc", 16'(x.a), 16'(acc));
         cmp("breg", 16'h0000, 16'(breg));
         cmp("pointer", x.dp, pointer16_reg);
         cmp("carry", 16'(x.c), 16'(carry));
         cmp("wrap_flag", 16'(x.ov), 16'(signed_wrap_flag));
         cmp("ram", 16'(x.mv), 16'(cbl_far_model_inst.ram[x.ma]));
         cmp("bit", 16'(x.bv), 16'(cbl_far_model_inst.bits[x.ba]));
      end
   end
   // every data write must hit the noted byte and name its space; the oldest
   // note still belongs to the running instruction at this edge
   always @(posedge clk) begin
      if (rstn === 1'b1 && mem_req.wr === 1'b1 && expq.size() > 0) begin
         cmp("mem_addr", 16'(expq[0].ma), 16'(mem_req.addr));
         cmp("is_sfr", 16'(expq[0].ma >= SFR_BASE), 16'(mem_req.is_sfr));
      end
   end
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      print_verdict();
   end
   ////////////////////////////////////////////////////////////////////
   initial begin
      e = '0;
      e.ma = D;
      e.ba = 8'h20;
      for (int i = 0; i < 256; i++) begin
         rnd = lfsr(rnd);
         sh[i] = rnd[7:0];
         shb[i] = rnd[8];
         cbl_far_model_inst.ram[i] = sh[i];
         cbl_far_model_inst.bits[i] = shb[i];
         cbl_far_model_inst.rom[i] = 8'h00;
      end
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      // accumulator wraps leave carry alone
      load_a(rnd[15:8]);
      issue(OP_INC_A, NB, NB, nx(1), e.a + 8'h01);
      issue(OP_DEC_A, NB, NB, nx(1), e.a - 8'h01);
      set_c(1'b1);
      load_a(8'h00);
      issue(OP_DEC_A, NB, NB, nx(1), 8'hff);
      issue(OP_INC_A, NB, NB, nx(1), 8'h00);
      e.c = 1'b0;
      issue(OP_ZERO_C, NB, NB, nx(1), e.a);
      // direct byte and working register forms
      load_a(rnd[23:16]);
      sh[D] = sh[D] + 8'h01;
      issue(OP_INC_DIR, D, NB, nx(2), e.a);
      sh[D] = sh[D] - 8'h01;
      issue(OP_DEC_DIR, D, NB, nx(2), e.a);
      sh[D] = sh[D] - 8'h01;
      issue(OP_DEC_DIR, D, NB, nx(2), e.a);
      issue(OP_AND_A_DIR, D, NB, nx(2), e.a & sh[D]);
      issue({GRP_AND, 4'ha}, NB, NB, nx(1), e.a & sh[2]);
      // working register and indirect forms, then direct writes, sfr byte included
      e.ma = 8'h03;
      sh[3] = sh[3] + 8'h01;
      issue({GRP_INC, 4'hb}, NB, NB, nx(1), e.a);
      e.ma = sh[1];
      sh[e.ma] = sh[e.ma] - 8'h01;
      issue({GRP_DEC, 4'h7}, NB, NB, nx(1), e.a);
      issue({GRP_AND, 4'h6}, NB, NB, nx(1), e.a & sh[sh[0]]);
      e.ma = D;
      load_a(rnd[31:24]);
      sh[D] = sh[D] & e.a;
      issue(OP_AND_DIR_A, D, NB, nx(2), e.a);
      e.ma = 8'h90;
      sh[8'h90] = sh[8'h90] + 8'h01;
      issue(OP_INC_DIR, 8'h90, NB, nx(2), e.a);
      // bit clear and complement, port bit included
      e.ba = 8'h90;
      shb[8'h90] = ~shb[8'h90];
      issue(OP_INV_BIT, 8'h90, NB, nx(2), e.a);
      for (int k = 0; k < 2; k++) begin
         e.ba = 8'h20 + 8'(k);
         shb[e.ba] = 1'b0;
         issue(OP_ZERO_BIT, e.ba, NB, nx(2), e.a);
      end
      shb[8'h21] = 1'b1;
      issue(OP_INV_BIT, 8'h21, NB, nx(2), e.a);
      set_c(1'b1);
      issue(OP_AND_C_BIT, 8'h21, NB, nx(2), e.a);
      e.c = 1'b0;
      issue(OP_AND_C_NBIT, 8'h21, NB, nx(2), e.a);
      // decimal adjust table: input, carry in, result, carry out
      for (int k = 0; k < 3; k++) begin
         load_a(k == 0 ? 8'h0b : (k == 1 ? 8'h45 : 8'h48));
         set_c(k == 2);
         e.c = (k == 2);
         issue(OP_BCD, NB, NB, nx(1), k == 0 ? 8'h71 : (k == 1 ? 8'h45 : 8'hae));
      end
      // compare: below, equal, above, with random signed offsets
      load_a({2'b01, rnd[5:0]});
      for (int k = 0; k < 3; k++) begin
         rnd = lfsr(rnd);
         imm = e.a + 8'(k) - 8'h01;
         e.c = (e.a < imm);
         issue(OP_CMP_A_IMM, imm, rnd[7:0], (imm != e.a) ? br(3, rnd[7:0]) : nx(3), e.a);
      end
      e.ma = D;
      e.c = (e.a < sh[D]);
      issue(OP_CMP_A_DIR, D, 8'h80, (sh[D] != e.a) ? br(3, 8'h80) : nx(3), e.a);
      // register operand against a random immediate
      rnd = lfsr(rnd);
      e.c = (sh[5] < rnd[7:0]);
      issue({GRP_CMP, 4'hd}, rnd[7:0], 8'h05,
         (sh[5] != rnd[7:0]) ? br(3, 8'h05) : nx(3), e.a);
      // divide by zero: flag set, carry cleared
      set_c(1'b1);
      e.c = 1'b0;
      e.ov = 1'b1;
      issue(OP_DIVIDE, NB, NB, nx(1), e.a);
      // count down from one, then wrap to 255
      sh[D] = 8'h00;
      issue(OP_AND_DIR_IMM, D, 8'h00, nx(3), e.a);
      sh[D] = sh[D] + 8'h01;
      issue(OP_INC_DIR, D, NB, nx(2), e.a);
      for (int k = 0; k < 2; k++) begin
         sh[D] = sh[D] - 8'h01;
         issue(OP_CNT_DIR, D, 8'h7f, (sh[D] != 8'h00) ? br(3, 8'h7f) : nx(3), e.a);
      end
      e.ma = 8'h02;
      sh[2] = sh[2] - 8'h01;
      issue({GRP_CNT_REG, 3'h2}, 8'hf0, NB, (sh[2] != 8'h00) ? br(2, 8'hf0) : nx(2), e.a);
      // bit branches, set and clear
      for (int k = 0; k < 4; k++) begin
         rnd = lfsr(rnd);
         e.ba = 8'h20 + 8'(k);
         issue(OP_BR_BIT, e.ba, rnd[7:0], shb[e.ba] ? br(3, rnd[7:0]) : nx(3), e.a);
         tk = shb[e.ba];
         shb[e.ba] = 1'b0;
         issue(OP_BR_CLR, e.ba, rnd[15:8], tk ? br(3, rnd[15:8]) : nx(3), e.a);
      end
      for (int k = 0; k < 2; k++) begin
         set_c(k == 1);
         issue(OP_BR_C, 8'hfa, NB, e.c ? br(2, 8'hfa) : nx(2), e.a);
      end
      for (int k = 0; k < 2; k++) begin
         e.dp = e.dp + 16'h0001;
         issue(OP_INC_PTR, NB, NB, nx(1), e.a);
      end
      issue(OP_IDX_JUMP, NB, NB, e.dp + {8'h00, e.a}, e.a);
      // every page jump opcode; the last lands where the next byte crosses 2k
      for (int k = 0; k < 8; k++) begin
         rnd = lfsr(rnd);
         imm = {3'(k), OP_PAGE_JUMP_LOW5};
         off = (k == 7) ? 8'hfe : rnd[7:0];
         issue(imm, off, NB, pj(imm, off), e.a);
      end
      issue(8'h21, 8'h10, NB, pj(8'h21, 8'h10), e.a);
      for (int i = 0; i < 12 && expq.size() > 0; i++) begin
         @(posedge clk);
      end
      if (expq.size() > 0) begin
         err_total++;
      end
      print_verdict();
   end
endmodule
